// ### logic/sadm_pkg.sv
// Constants for the system address map decoder.
// Assumes a single clock domain and a flat 32-bit byte address.
// How it works
// - Every address is a 32-bit byte address in one 4 Gbyte space.
// - 0xffe00000 to 0xffffffff selects the core register area.
// - 0xffc00000 to 0xffdfffff selects the system register area.
// - 4K scratchpad at 0xffb00000; rest up to 0xffc00000 reserved.
// - 16K instruction memory at 0xffa00000; rest up to scratchpad reserved.
// - 16K data bank B at 0xff900000; rest of its megabyte reserved.
// - 16K data bank A at 0xff800000; rest of its megabyte reserved.
// - 256K level two memory at 0xf0000000; above it reserved.
// - Word at 0xeefffffc is the PCI config port; 0xef000000 up reserved.
// - 0xeeffff00 up to the config port selects PCI config registers.
// - 64K PCI I/O window at 0xeefe0000; gap above reserved.
// - 128M PCI memory window at 0xe0000000; 0xe8000000 upward reserved.
// - Four 64M async banks from 0x20000000; 0x30000000 upward reserved.
// - SDRAM bank 0 starts at zero; each bank 16M to 128M.
// - SDRAM banks are packed contiguously, each only its own size.
// - Space past SDRAM bank 3 below 0x20000000 is reserved.
// - SDRAM and async regions route to the external bus unit.
// - Instruction memory only for fetches; level two serves both.

package sadm_pkg;

  localparam int ADDR_W = 32;
  localparam int SDRAM_BANKS = 4;
  localparam int ASYNC_BANKS = 4;

  // ------------------------------------------------------------------
  // Region bases and limits (inclusive).
  // ------------------------------------------------------------------
  localparam logic [31:0] CORE_REG_BASE = 32'hffe0_0000;
  localparam logic [31:0] SYS_REG_BASE = 32'hffc0_0000;
  localparam logic [31:0] SYS_REG_LAST = 32'hffdf_ffff;
  localparam logic [31:0] SCRATCH_BASE = 32'hffb0_0000;
  localparam logic [31:0] SCRATCH_LAST = 32'hffb0_0fff;
  localparam logic [31:0] INSTR_BASE = 32'hffa0_0000;
  localparam logic [31:0] INSTR_LAST = 32'hffa0_3fff;
  localparam logic [31:0] DATAB_BASE = 32'hff90_0000;
  localparam logic [31:0] DATAB_LAST = 32'hff90_3fff;
  localparam logic [31:0] DATAA_BASE = 32'hff80_0000;
  localparam logic [31:0] DATAA_LAST = 32'hff80_3fff;
  localparam logic [31:0] LTWO_BASE = 32'hf000_0000;
  localparam logic [31:0] LTWO_LAST = 32'hf003_ffff;
  localparam logic [31:0] PCI_CFGPORT_BASE = 32'heeff_fffc;
  localparam logic [31:0] PCI_CFGPORT_LAST = 32'heeff_ffff;
  localparam logic [31:0] PCI_CFGREG_BASE = 32'heeff_ff00;
  localparam logic [31:0] PCI_IO_BASE = 32'heefe_0000;
  localparam logic [31:0] PCI_IO_LAST = 32'heefe_ffff;
  localparam logic [31:0] PCI_MEM_BASE = 32'he000_0000;
  localparam logic [31:0] PCI_MEM_LAST = 32'he7ff_ffff;
  localparam logic [31:0] ASYNC_BASE = 32'h2000_0000;
  localparam logic [31:0] ASYNC_LAST = 32'h2fff_ffff;
  localparam int ASYNC_SEL_LSB = 26;

  // ------------------------------------------------------------------
  // SDRAM bank sizes in 16M units, from 1 (16M) to 8 (128M).
  // ------------------------------------------------------------------
  localparam int SIZE_W = 4;
  localparam int SIZE_UNIT_LSB = 24;
  localparam logic [SIZE_W-1:0] SIZE_MIN = 4'h1;
  localparam logic [SIZE_W-1:0] SIZE_MAX = 4'h8;
  localparam logic [SIZE_W-1:0] SIZE_RESET = 4'h8;

  // ------------------------------------------------------------------
  // Target encoding; one-hot select is indexed by this code.
  // ------------------------------------------------------------------
  localparam int TGT_N = 19;
  typedef enum logic [4:0] {
    TGT_SDRAM0 = 5'h00,
    TGT_SDRAM1 = 5'h01,
    TGT_SDRAM2 = 5'h02,
    TGT_SDRAM3 = 5'h03,
    TGT_ASYNC0 = 5'h04,
    TGT_ASYNC1 = 5'h05,
    TGT_ASYNC2 = 5'h06,
    TGT_ASYNC3 = 5'h07,
    TGT_PCI_MEM = 5'h08,
    TGT_PCI_IO = 5'h09,
    TGT_PCI_CFGREG = 5'h0a,
    TGT_PCI_CFGPORT = 5'h0b,
    TGT_LTWO = 5'h0c,
    TGT_DATAA = 5'h0d,
    TGT_DATAB = 5'h0e,
    TGT_INSTR = 5'h0f,
    TGT_SCRATCH = 5'h10,
    TGT_SYS_REG = 5'h11,
    TGT_CORE_REG = 5'h12,
    TGT_NONE = 5'h1f
  } sadm_target_type;

endpackage : sadm_pkg

// ### logic/sadm_decoder.sv
// Registered address decoder for the flat system address map.
// Assumes requests come from logic on the same clock, one per cycle.
`timescale 1ns/1ps

module sadm_decoder (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // SDRAM bank sizes, 16M units each, packed bank 0 in the low bits.
  input wire logic [sadm_pkg::SDRAM_BANKS*sadm_pkg::SIZE_W-1:0] bankSize,
  // Request.
  input wire logic reqValid,
  input wire logic [sadm_pkg::ADDR_W-1:0] reqAddr,
  input wire logic reqFetch,
  // Decoded answer.
  output logic selValid,
  output logic [sadm_pkg::TGT_N-1:0] targetSel,
  output logic [4:0] targetCode,
  output logic [sadm_pkg::ADDR_W-1:0] selAddr,
  output logic externalSel,
  output logic decodeError
);
  import sadm_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration checks.
  // ------------------------------------------------------------------
  // The decode chain is written out for four banks of each kind.
  if (SDRAM_BANKS != 4 || ASYNC_BANKS != 4) begin : g_bank_check
    $error("decoder serves exactly four SDRAM and four async banks");
  end
  // The one-hot select must hold every target code.
  if (TGT_N != 19 || ADDR_W != 32) begin : g_width_check
    $error("target count or address width not supported");
  end

  // ------------------------------------------------------------------
  // SDRAM bank boundaries.
  // ------------------------------------------------------------------
  // Sizes outside 16M..128M are clamped so the map stays well formed.
  logic [SIZE_W-1:0] sizeClamp [SDRAM_BANKS];
  logic [ADDR_W-1:0] bankEnd [SDRAM_BANKS];

  always_comb begin
    for (int i = 0; i < SDRAM_BANKS; i++) begin
      sizeClamp[i] = bankSize[i*SIZE_W +: SIZE_W];
      if (sizeClamp[i] < SIZE_MIN) begin
        sizeClamp[i] = SIZE_MIN;
      end else if (sizeClamp[i] > SIZE_MAX) begin
        sizeClamp[i] = SIZE_MAX;
      end
    end
  end

  // Each end is the running sum of all sizes up to this bank.
  always_comb begin
    logic [ADDR_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < SDRAM_BANKS; i++) begin
      acc = acc + (ADDR_W'(sizeClamp[i]) << SIZE_UNIT_LSB);
      bankEnd[i] = acc;
    end
  end

  // ------------------------------------------------------------------
  // Combinational region decode.
  // ------------------------------------------------------------------
  sadm_target_type tgt;
  logic [ADDR_W-1:0] a;

  assign a = reqAddr;

  always_comb begin
    tgt = TGT_NONE;
    if (a >= CORE_REG_BASE) begin
      tgt = TGT_CORE_REG;
    end else if (a >= SYS_REG_BASE && a <= SYS_REG_LAST) begin
      tgt = TGT_SYS_REG;
    end else if (a >= SCRATCH_BASE && a <= SCRATCH_LAST) begin
      tgt = TGT_SCRATCH;
    end else if (a >= INSTR_BASE && a <= INSTR_LAST) begin
      // Instruction memory answers fetches only.
      tgt = reqFetch ? TGT_INSTR : TGT_NONE;
    end else if (a >= DATAB_BASE && a <= DATAB_LAST) begin
      tgt = TGT_DATAB;
    end else if (a >= DATAA_BASE && a <= DATAA_LAST) begin
      tgt = TGT_DATAA;
    end else if (a >= LTWO_BASE && a <= LTWO_LAST) begin
      tgt = TGT_LTWO;
    end else if (a >= PCI_CFGPORT_BASE && a <= PCI_CFGPORT_LAST) begin
      tgt = TGT_PCI_CFGPORT;
    end else if (a >= PCI_CFGREG_BASE && a < PCI_CFGPORT_BASE) begin
      tgt = TGT_PCI_CFGREG;
    end else if (a >= PCI_IO_BASE && a <= PCI_IO_LAST) begin
      tgt = TGT_PCI_IO;
    end else if (a >= PCI_MEM_BASE && a <= PCI_MEM_LAST) begin
      tgt = TGT_PCI_MEM;
    end else if (a >= ASYNC_BASE && a <= ASYNC_LAST) begin
      tgt = sadm_target_type'(5'(TGT_ASYNC0) +
        5'(a[ASYNC_SEL_LSB +: 2]));
    end else if (a < bankEnd[0]) begin
      tgt = TGT_SDRAM0;
    end else if (a < bankEnd[1]) begin
      tgt = TGT_SDRAM1;
    end else if (a < bankEnd[2]) begin
      tgt = TGT_SDRAM2;
    end else if (a < bankEnd[3]) begin
      tgt = TGT_SDRAM3;
    end else begin
      tgt = TGT_NONE;
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs.
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      selValid <= 1'b0;
      targetCode <= 5'h1f;
      selAddr <= '0;
    end else begin
      selValid <= reqValid;
      targetCode <= reqValid ? 5'(tgt) : 5'h1f;
      selAddr <= reqAddr;
    end
  end

  // A reserved address raises no select, only the error flag.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      targetSel <= '0;
      decodeError <= 1'b0;
    end else begin
      targetSel <= '0;
      decodeError <= reqValid && (tgt == TGT_NONE);
      if (reqValid && tgt != TGT_NONE) begin
        targetSel[tgt] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      externalSel <= 1'b0;
    end else begin
      externalSel <= reqValid && (tgt <= TGT_ASYNC3);
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  a_one_hot_sel: assert property (@(posedge clock) disable iff (rst)
    $onehot0(targetSel) && !(decodeError && targetSel != '0)
    && (selValid == (decodeError || targetSel != '0)))
    else $error("select not one-hot or error with select");
  a_core_reg: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr >= 32'hffe0_0000 |=> targetSel[TGT_CORE_REG])
    else $error("core register area not selected");
  a_sys_reg: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:21] == 11'h7fe |=> targetSel[TGT_SYS_REG])
    else $error("system register area not selected");
  a_scratch_gap: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr == 32'hffb0_1000 |=> decodeError)
    else $error("scratchpad gap not reserved");
  a_instr_fetch: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:14] == 18'h3fe80 && !reqFetch |=> decodeError)
    else $error("data access reached instruction memory");
  a_ltwo_edge: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr == 32'hf004_0000 |=> decodeError)
    else $error("level two upper edge not reserved");
  a_cfg_port: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:2] == 30'h3bbf_ffff
    |=> targetSel[TGT_PCI_CFGPORT])
    else $error("config port not selected");
  a_async_bank: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:28] == 4'h2
    |=> targetCode == 5'h04 + 5'($past(reqAddr[27:26])) && externalSel)
    else $error("async bank order wrong");
  a_sdram_zero: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr == 32'h0 |=> targetSel[TGT_SDRAM0] && externalSel)
    else $error("address zero not in SDRAM bank 0");
  a_sdram_gap: assert property (@(posedge clock) disable iff (rst)
    reqValid && reqAddr < 32'h2000_0000 && reqAddr >= bankEnd[3]
    |=> decodeError && !externalSel)
    else $error("space past SDRAM bank 3 not reserved");

  // A taken request always gets an answer on the next edge.
  a_answer_follows: assert property (
    @(posedge clock) disable iff (rst)
    reqValid |=> selValid)
    else $error("taken request got no answer");

  // With no request, every select and the error flag stay low.
  a_idle_quiet: assert property (
    @(posedge clock) disable iff (rst)
    !reqValid |=> !selValid && targetSel == '0 && !decodeError
    && targetCode == 5'h1f)
    else $error("answer without a request");

  // The select bit always matches the reported target code.
  a_code_match: assert property (
    @(posedge clock) disable iff (rst)
    selValid && !decodeError |-> targetSel == (TGT_N'(1) << targetCode))
    else $error("select bit and target code disagree");

  // Only SDRAM and async targets go to the external bus unit.
  a_external_route: assert property (
    @(posedge clock) disable iff (rst)
    selValid |-> externalSel == (targetCode <= 5'h07))
    else $error("external route flag wrong");

  // The whole scratchpad page selects the scratchpad.
  a_scratch_sel: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:12] == 20'hffb00 |=> targetSel[TGT_SCRATCH])
    else $error("scratchpad not selected");

  // A fetch inside the instruction memory selects it.
  a_instr_sel: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:14] == 18'h3fe80 && reqFetch
    |=> targetSel[TGT_INSTR])
    else $error("instruction memory not selected");

  // Past the instruction memory, its megabyte is reserved.
  a_instr_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:20] == 12'hffa && reqAddr[19:14] != 6'h00
    |=> decodeError)
    else $error("instruction gap not reserved");

  // Data bank B answers its 16K range.
  a_datab_sel: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:14] == 18'h3fe40 |=> targetSel[TGT_DATAB])
    else $error("data bank B not selected");

  // Past data bank B, its megabyte is reserved.
  a_datab_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:20] == 12'hff9 && reqAddr[19:14] != 6'h00
    |=> decodeError)
    else $error("data bank B gap not reserved");

  // Data bank A answers its 16K range.
  a_dataa_sel: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:14] == 18'h3fe00 |=> targetSel[TGT_DATAA])
    else $error("data bank A not selected");

  // Past data bank A, its megabyte is reserved.
  a_dataa_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:20] == 12'hff8 && reqAddr[19:14] != 6'h00
    |=> decodeError)
    else $error("data bank A gap not reserved");

  // Level two memory answers its whole range.
  a_ltwo_sel: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:18] == 14'h3c00 |=> targetSel[TGT_LTWO])
    else $error("level two memory not selected");

  // Level two memory also serves plain data accesses.
  a_ltwo_data: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && !reqFetch && reqAddr[31:18] == 14'h3c00
    |=> targetSel[TGT_LTWO])
    else $error("data access refused by level two memory");

  // The band above the config port is reserved.
  a_cfg_high_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:24] == 8'hef |=> decodeError)
    else $error("band above config port not reserved");

  // The last page below the config port holds the config registers.
  a_cfg_regs: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:8] == 24'heeffff && reqAddr[7:2] != 6'h3f
    |=> targetSel[TGT_PCI_CFGREG])
    else $error("config registers not selected");

  // The PCI I/O window answers its 64K range.
  a_pci_io: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:16] == 16'heefe |=> targetSel[TGT_PCI_IO])
    else $error("PCI I/O window not selected");

  // Between the I/O window and the config registers is reserved.
  a_pci_io_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:16] == 16'heeff && reqAddr[15:8] != 8'hff
    |=> decodeError)
    else $error("gap below config registers not reserved");

  // The PCI memory window answers its 128M range.
  a_pci_mem: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:27] == 5'h1c |=> targetSel[TGT_PCI_MEM])
    else $error("PCI memory window not selected");

  // Just above the PCI memory window is reserved.
  a_pci_mem_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:24] == 8'he8 |=> decodeError)
    else $error("space above PCI memory not reserved");

  // The band above the async banks is reserved.
  a_async_gap: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr[31:28] == 4'h3 |=> decodeError)
    else $error("space above async banks not reserved");

  // No SDRAM bank ever reaches the async region.
  a_sdram_ceiling: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && reqAddr >= 32'h2000_0000 |=> targetCode > 5'h03)
    else $error("SDRAM bank above its ceiling");

  // The last byte of a legal bank 0 still belongs to bank 0.
  a_sdram_end: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && bankSize[3:0] != 4'h0 && bankSize[3:0] <= 4'h8
    && reqAddr == (32'(bankSize[3:0]) << 24) - 32'h1
    |=> targetSel[TGT_SDRAM0])
    else $error("bank 0 cut short");

  // Bank 1 starts right where the configured bank 0 size ends.
  a_sdram_next: assert property (
    @(posedge clock) disable iff (rst)
    reqValid && bankSize[3:0] != 4'h0 && bankSize[3:0] <= 4'h8
    && reqAddr == (32'(bankSize[3:0]) << 24)
    |=> targetSel[TGT_SDRAM1])
    else $error("bank 1 start not packed after bank 0");

  c_cfg_port: cover property (@(posedge clock) targetSel[TGT_PCI_CFGPORT]);
  c_sdram: cover property (@(posedge clock) targetSel[TGT_SDRAM3]);
  c_error: cover property (@(posedge clock) decodeError);
  c_pci_io: cover property (@(posedge clock) targetSel[TGT_PCI_IO]);
  c_instr: cover property (@(posedge clock) targetSel[TGT_INSTR]);

endmodule : sadm_decoder

// ### sim/sadm_master_model.sv
// Bus master model that issues decode requests for the bench.
// Assumes commands change at the falling edge of the decoder clock.
`timescale 1ns/1ps

module sadm_master_model (
  // Clock.
  input wire logic clock,
  // Commands from the bench.
  input wire logic cmdValid,
  input wire logic [sadm_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic cmdFetch,
  // Request to the decoder.
  output logic reqValid,
  output logic [sadm_pkg::ADDR_W-1:0] reqAddr,
  output logic reqFetch
);
  logic [sadm_pkg::ADDR_W-1:0] lastAddr_r = '0;

  // Idle address lines toggle so a stale address is never mistaken.
  always @(negedge clock) begin
    lastAddr_r <= reqAddr;
  end

  assign reqValid = cmdValid;
  assign reqAddr = cmdValid ? cmdAddr : ~lastAddr_r;
  assign reqFetch = cmdValid ? cmdFetch : lastAddr_r[0];
endmodule : sadm_master_model

// ### sim/tb_sadm_decoder.sv
// Self-checking bench for the system address map decoder.
// Assumes the master model drives requests; bench acts at falling edges.
`timescale 1ns/1ps

module tb_sadm_decoder;
  import sadm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bankSize = 16'h8888;
  logic cmdValid = 1'b0;
  logic [31:0] cmdAddr = 32'h0;
  logic cmdFetch = 1'b0;
  logic reqValid, reqFetch, selValid, externalSel, decodeError;
  logic [31:0] reqAddr, selAddr, pendAddr;
  logic [18:0] targetSel;
  logic [4:0] targetCode, pendCode;
  logic hasPend = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #50 clock = ~clock;

  sadm_master_model master_u (.clock(clock), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .cmdFetch(cmdFetch), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqFetch(reqFetch));

  sadm_decoder dut_u (.clock(clock), .rst(rst), .bankSize(bankSize),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch),
    .selValid(selValid), .targetSel(targetSel), .targetCode(targetCode),
    .selAddr(selAddr), .externalSel(externalSel),
    .decodeError(decodeError));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Judges the previous request's answer, then issues the next one.
  task automatic step(input logic v, input logic [31:0] a,
                      input logic f, input logic [4:0] c);
    logic [31:0] hot;
    @(negedge clock);
    hot = (pendCode == 5'h1f) ? 32'h0 : 32'h1 << pendCode;
    if (hasPend) begin
      check(32'(selValid), 32'h1);
      check(32'(targetCode), 32'(pendCode));
      check(32'(targetSel), hot);
      check(32'(decodeError), 32'(pendCode == 5'h1f));
      check(32'(externalSel), 32'(pendCode < 5'h08));
      check(selAddr, pendAddr);
    end else begin
      check({selValid, decodeError, targetSel}, 32'h0);
      check(32'(targetCode), 32'h1f);
    end
    cmdValid = v;
    cmdAddr = a;
    cmdFetch = f;
    hasPend = v;
    pendCode = c;
    pendAddr = a;
  endtask : step

  task automatic map_sweep;
    logic [31:0] a [45] = '{32'hffffffff, 32'hffe00000, 32'hffdfffff,
      32'hffc00000, 32'hffbfffff, 32'hffb01000, 32'hffb00fff, 32'hffb00000,
      32'hffafffff, 32'hffa04000, 32'hffa03fff, 32'hffa00000, 32'hff904000,
      32'hff903fff, 32'hff900000, 32'hff804000, 32'hff803fff, 32'hff800000,
      32'hff7fffff, 32'hf0040000, 32'hf003ffff, 32'hf0000000, 32'hefffffff,
      32'hef000000, 32'heefffffc, 32'heeffffff, 32'heefffffb, 32'heeffff00,
      32'heefffeff, 32'heeff0000, 32'heefeffff, 32'heefe0000, 32'heefdffff,
      32'he8000000, 32'he7ffffff, 32'he0000000, 32'hdfffffff, 32'h30000000,
      32'h2fffffff, 32'h2c000000, 32'h2bffffff, 32'h28000000, 32'h24000000,
      32'h23ffffff, 32'h20000000};
    logic [4:0] c [45] = '{5'h12, 5'h12, 5'h11, 5'h11, 5'h1f, 5'h1f, 5'h10,
      5'h10, 5'h1f, 5'h1f, 5'h0f, 5'h0f, 5'h1f, 5'h0e, 5'h0e, 5'h1f, 5'h0d,
      5'h0d, 5'h1f, 5'h1f, 5'h0c, 5'h0c, 5'h1f, 5'h1f, 5'h0b, 5'h0b, 5'h0a,
      5'h0a, 5'h1f, 5'h1f, 5'h09, 5'h09, 5'h1f, 5'h1f, 5'h08, 5'h08, 5'h1f,
      5'h1f, 5'h07, 5'h07, 5'h06, 5'h06, 5'h05, 5'h04, 5'h04};
    for (int i = 0; i < 22; i++) begin
      step(1'b1, a[i], 1'b1, c[i]);
    end
    for (int i = 22; i < 45; i++) begin
      step(1'b1, a[i], 1'b1, c[i]);
    end
    step(1'b1, 32'hff903ffc, 1'b0, 5'h0e);
  endtask : map_sweep

  task automatic fetch_kinds;
    step(1'b1, 32'hffa00000, 1'b0, 5'h1f);
    step(1'b1, 32'hf0000000, 1'b0, 5'h0c);
    step(1'b1, 32'hffa03fff, 1'b1, 5'h0f);
    step(1'b1, 32'hf003fffc, 1'b1, 5'h0c);
  endtask : fetch_kinds

  task automatic sdram_packing;
    step(1'b0, 32'h0, 1'b0, 5'h1f);
    bankSize = 16'h3281;
    step(1'b1, 32'h00000000, 1'b0, 5'h00);
    step(1'b1, 32'h00ffffff, 1'b0, 5'h00);
    step(1'b1, 32'h01000000, 1'b0, 5'h01);
    step(1'b1, 32'h08ffffff, 1'b0, 5'h01);
    step(1'b1, 32'h09000000, 1'b0, 5'h02);
    step(1'b1, 32'h0b000000, 1'b0, 5'h03);
    step(1'b1, 32'h0dffffff, 1'b0, 5'h03);
    step(1'b1, 32'h0e000000, 1'b0, 5'h1f);
    step(1'b1, 32'h1fffffff, 1'b0, 5'h1f);
    step(1'b0, 32'h0, 1'b0, 5'h1f);
    bankSize = 16'h8888;
    step(1'b1, 32'h1fffffff, 1'b0, 5'h03);
    step(1'b1, 32'h17ffffff, 1'b0, 5'h02);
  endtask : sdram_packing

  task automatic test_done;
    $display("Mismatches %0d in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    map_sweep();
    fetch_kinds();
    sdram_packing();
    step(1'b0, 32'h0, 1'b0, 5'h1f);
    step(1'b0, 32'h0, 1'b0, 5'h1f);
    test_done();
  end
endmodule : tb_sadm_decoder
